/* core/sfp_regs.vh */
// Behaviour
// RULE1 - chip select high: standby, serial input ignored, output released
// RULE2 - device is active for an operation only while chip select is low
// RULE3 - write-protect pin low: region-lock bits decide protection; high: pin protects nothing
// RULE4 - quad mode bit set: write-protect function off, pin becomes data lane 2
// RULE5 - quad mode bit set: pause function off, pin becomes data lane 3
// RULE6 - pause holds the partial serial sequence intact so the transfer resumes
// RULE7 - only clock modes 0 and 3; idle clock level picks the mode
// RULE8 - sample on rising clock edge, launch output on falling clock edge
// RULE9 - array is 4 KByte sectors, sixteen per 64 KByte block
// RULE10 - addresses 000000h to 03ffffh; block n at n*010000h, sector m at m*001000h
// RULE11 - instruction, address and data shift in msb first after select goes low
// RULE12 - address bits above bit 17 are ignored when decoding into the array
`ifndef SFP_REGS_VH
`define SFP_REGS_VH
`define SFP_ADDR_BITS 18
`define SFP_SECTOR_LSB 12
`define SFP_BLOCK_LSB 16
`define SFP_ADDR_MAX 18'h3ffff
`define SFP_FIFO_DEPTH 8
`define SFP_FIFO_AW 3
`endif

/* core/sfp_fifo.v */
`timescale 1ns/1ps
module sfp_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 8,
  parameter AW = 3
) (
  input wire clk_sys,
  input wire rstn,
  input wire clear,
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  output wire out_valid,
  input wire out_ready,
  output reg [WIDTH-1:0] out_data
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW:0] wr_reg;
  reg [AW:0] rd_reg;
  reg have_reg;
  wire [AW:0] used = wr_reg - rd_reg;
  wire full = (used == DEPTH[AW:0]);
  wire empty = (used == {(AW+1){1'b0}});
  wire pop = out_valid && out_ready;
  // read data comes from a register; one staged word sits in out_data
  wire load = !empty && (!have_reg || pop);
  assign in_ready = !full;
  assign out_valid = have_reg;
  always @(posedge clk_sys)
  begin
    if (in_valid && !full)
      mem[wr_reg[AW-1:0]] <= in_data;
  end
  always @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      wr_reg <= {(AW+1){1'b0}};
      rd_reg <= {(AW+1){1'b0}};
      have_reg <= 1'b0;
      out_data <= {WIDTH{1'b0}};
    end
    else if (clear)
    begin
      wr_reg <= {(AW+1){1'b0}};
      rd_reg <= {(AW+1){1'b0}};
      have_reg <= 1'b0;
    end
    else
    begin
      if (in_valid && !full)
        wr_reg <= wr_reg + 1'b1;
      if (load)
      begin
        out_data <= mem[rd_reg[AW-1:0]];
        rd_reg <= rd_reg + 1'b1;
        have_reg <= 1'b1;
      end
      else if (pop)
        have_reg <= 1'b0;
    end
  end
endmodule // sfp_fifo

/* core/sfp_spi_front.v */
`timescale 1ns/1ps
`include "sfp_regs.vh"
module sfp_spi_front (
  input wire clk_sys,
  input wire rstn,
  input wire cs_n,
  input wire sck,
  input wire si_in,
  output wire si_out,
  output wire si_oe,
  output wire so_out,
  output wire so_oe,
  input wire data_lane2_in,
  output wire data_lane2_out,
  output wire data_lane2_oe,
  input wire data_lane3_in,
  output wire data_lane3_out,
  output wire data_lane3_oe,
  input wire quad_mode_bit,
  input wire region_lock_bit0,
  input wire region_lock_bit1,
  input wire region_lock_bit2,
  input wire region_lock_bit3,
  input wire quad_rx,
  input wire tx_enable,
  input wire tx_valid,
  output wire tx_ready,
  input wire [7:0] tx_data,
  output reg cmd_valid,
  output reg [7:0] cmd_code,
  output reg addr_valid,
  output reg [17:0] array_addr,
  output reg [5:0] sector_index,
  output reg [1:0] block_index,
  output wire rx_valid,
  input wire rx_ready,
  output wire [7:0] rx_data,
  output wire rx_overflow,
  output reg clock_mode3,
  output wire selected,
  output wire write_protect_active,
  output wire [3:0] region_lock_eff,
  output reg frame_end
);
  reg [1:0] cs_s;
  reg [1:0] sck_s;
  reg [1:0] hold_s;
  reg [1:0] wp_s;
  reg [3:0] din_s0;
  reg [3:0] din_s1;
  reg sck_d_reg;
  reg [3:0] state_reg;
  reg [7:0] shift_reg;
  reg [2:0] bit_cnt_reg;
  reg [1:0] byte_cnt_reg;
  reg [23:0] addr_acc_reg;
  reg [7:0] tx_sh_reg;
  reg [3:0] tx_cnt_reg;
  reg tx_load_reg;
  reg [3:0] out_bits_reg;
  reg drive_reg;
  reg ovf_reg;
  reg rx_push;
  reg [7:0] rx_word;
  wire fifo_in_ready;
  localparam [3:0] ST_IDLE = 4'h1;
  localparam [3:0] ST_CMD = 4'h2;
  localparam [3:0] ST_ADDR = 4'h4;
  localparam [3:0] ST_DATA = 4'h8;

  // synchronise every pin before use: the first flop feeds only the second
  always @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      cs_s <= 2'h3;
      sck_s <= 2'h0;
      hold_s <= 2'h3;
      wp_s <= 2'h3;
      din_s0 <= 4'h0;
      din_s1 <= 4'h0;
    end
    else
    begin
      cs_s <= {cs_s[0], cs_n};
      sck_s <= {sck_s[0], sck};
      hold_s <= {hold_s[0], data_lane3_in};
      wp_s <= {wp_s[0], data_lane2_in};
      din_s0 <= {data_lane3_in, data_lane2_in, so_out, si_in};
      din_s1 <= din_s0;
    end
  end

  wire cs_act = !cs_s[1];
  // RULE5 pause off in quad
  wire pause = !quad_mode_bit && !hold_s[1];
  // RULE8 edge detect
  wire rise = cs_act && !pause && sck_s[1] && !sck_d_reg;
  wire fall = cs_act && !pause && !sck_s[1] && sck_d_reg;
  wire quad_in = quad_mode_bit && quad_rx;
  // RULE11 msb first
  wire [7:0] shift_next = quad_in ? {shift_reg[3:0], din_s1} : {shift_reg[6:0], din_s1[0]};
  wire [2:0] bit_step = quad_in ? 3'h4 : 3'h1;
  wire byte_done = quad_in ? (bit_cnt_reg == 3'h4) : (bit_cnt_reg == 3'h7);

  // RULE2 active only while selected
  assign selected = cs_act;
  // RULE3 pin low lets lock bits apply
  // RULE4 quad mode disables the pin function
  assign write_protect_active = !quad_mode_bit && !wp_s[1];
  assign region_lock_eff = write_protect_active ?
    {region_lock_bit3, region_lock_bit2, region_lock_bit1, region_lock_bit0} : 4'h0;

  always @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      sck_d_reg <= 1'b0;
      state_reg <= ST_IDLE;
      shift_reg <= 8'h00;
      bit_cnt_reg <= 3'h0;
      byte_cnt_reg <= 2'h0;
      addr_acc_reg <= 24'h000000;
      cmd_valid <= 1'b0;
      cmd_code <= 8'h00;
      addr_valid <= 1'b0;
      array_addr <= 18'h00000;
      sector_index <= 6'h00;
      block_index <= 2'h0;
      rx_push <= 1'b0;
      rx_word <= 8'h00;
      clock_mode3 <= 1'b0;
      frame_end <= 1'b0;
      ovf_reg <= 1'b0;
    end
    else
    begin
      sck_d_reg <= sck_s[1];
      cmd_valid <= 1'b0;
      addr_valid <= 1'b0;
      rx_push <= 1'b0;
      frame_end <= 1'b0;
      // RULE7 idle level gives mode
      if (!cs_act)
        clock_mode3 <= sck_s[1];
      case (state_reg)
        ST_IDLE:
        begin
          bit_cnt_reg <= 3'h0;
          byte_cnt_reg <= 2'h0;
          if (cs_act)
          begin
            state_reg <= ST_CMD;
            ovf_reg <= 1'b0;
          end
        end
        default:
        begin
          // RULE1 deselect drops the frame
          if (!cs_act)
          begin
            state_reg <= ST_IDLE;
            frame_end <= 1'b1;
          end
          // RULE6 pause keeps counters and shift data
          else if (rise)
          begin
            shift_reg <= shift_next;
            bit_cnt_reg <= byte_done ? 3'h0 : bit_cnt_reg + bit_step;
            if (byte_done)
            begin
              case (state_reg)
                ST_CMD:
                begin
                  cmd_code <= shift_next;
                  cmd_valid <= 1'b1;
                  state_reg <= ST_ADDR;
                end
                ST_ADDR:
                begin
                  addr_acc_reg <= {addr_acc_reg[15:0], shift_next};
                  byte_cnt_reg <= byte_cnt_reg + 2'h1;
                  if (byte_cnt_reg == 2'h2)
                  begin
                    // RULE12 top address bits dropped
                    array_addr <= {addr_acc_reg[9:0], shift_next};
                    // RULE9 sector and block split
                    // RULE10 block n at n*010000h
                    sector_index <= {addr_acc_reg[9:8], addr_acc_reg[7:4]};
                    block_index <= addr_acc_reg[9:8];
                    addr_valid <= 1'b1;
                    state_reg <= ST_DATA;
                  end
                end
                default:
                begin
                  rx_word <= shift_next;
                  rx_push <= 1'b1;
                  if (!fifo_in_ready)
                    ovf_reg <= 1'b1;
                end
              endcase
            end
          end
        end
      endcase
    end
  end

  assign rx_overflow = ovf_reg;

  sfp_fifo #(
    .WIDTH(8),
    .DEPTH(`SFP_FIFO_DEPTH),
    .AW(`SFP_FIFO_AW)
  ) u_rx_fifo (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .clear(1'b0),
    .in_valid(rx_push),
    .in_ready(fifo_in_ready),
    .in_data(rx_word),
    .out_valid(rx_valid),
    .out_ready(rx_ready),
    .out_data(rx_data)
  );

  // output shifter: a byte is taken when the previous one is exhausted
  wire tx_empty = (tx_cnt_reg == 4'h0);
  assign tx_ready = cs_act && tx_enable && tx_empty && !tx_load_reg;
  wire [3:0] tx_dec = quad_mode_bit ? 4'h4 : 4'h1;

  always @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      tx_sh_reg <= 8'h00;
      tx_cnt_reg <= 4'h0;
      tx_load_reg <= 1'b0;
      out_bits_reg <= 4'h0;
      drive_reg <= 1'b0;
    end
    else if (!cs_act || !tx_enable)
    begin
      tx_cnt_reg <= 4'h0;
      tx_load_reg <= 1'b0;
      drive_reg <= 1'b0;
    end
    else
    begin
      if (tx_valid && tx_ready)
      begin
        tx_sh_reg <= tx_data;
        tx_cnt_reg <= 4'h8;
        tx_load_reg <= 1'b1;
      end
      // RULE8 launch on falling edge
      else if (fall && !tx_empty)
      begin
        drive_reg <= 1'b1;
        tx_load_reg <= 1'b0;
        if (quad_mode_bit)
        begin
          out_bits_reg <= tx_sh_reg[7:4];
          tx_sh_reg <= {tx_sh_reg[3:0], 4'h0};
        end
        else
        begin
          out_bits_reg <= {3'h0, tx_sh_reg[7]};
          tx_sh_reg <= {tx_sh_reg[6:0], 1'b0};
        end
        tx_cnt_reg <= tx_cnt_reg - tx_dec;
      end
    end
  end

  // RULE1 released while deselected
  assign so_oe = drive_reg && cs_act;
  assign so_out = quad_mode_bit ? out_bits_reg[1] : out_bits_reg[0];
  assign si_oe = drive_reg && cs_act && quad_mode_bit;
  assign si_out = out_bits_reg[0];
  // RULE4 lane 2 drives only in quad
  assign data_lane2_oe = si_oe;
  assign data_lane2_out = out_bits_reg[2];
  // RULE5 lane 3 drives only in quad
  assign data_lane3_oe = si_oe;
  assign data_lane3_out = out_bits_reg[3];
endmodule // sfp_spi_front

/* bench/sfp_monitor.sv */
`timescale 1ns/1ps
module sfp_monitor (
  input wire clk_sys,
  input wire rstn,
  input wire cs_n,
  input wire sck,
  input wire selected,
  input wire so_oe,
  input wire si_oe,
  input wire cmd_valid,
  input wire addr_valid,
  input wire [17:0] array_addr,
  input wire [5:0] sector_index,
  input wire [1:0] block_index,
  input wire quad_mode_bit,
  input wire write_protect_active,
  input wire [3:0] region_lock_eff,
  input wire data_lane2_oe,
  input wire data_lane3_oe,
  input wire data_lane3_in,
  input wire data_lane2_in,
  input wire clock_mode3
);
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (!rstn);
  AST_STANDBY: assert property (cs_n [*3] |-> !so_oe && !si_oe)
    else $error("output driven while deselected");
  AST_ACTIVE: assert property (cmd_valid || addr_valid |-> $past(selected))
    else $error("transfer taken while deselected");
  AST_SECTOR: assert property (addr_valid |-> sector_index == array_addr[17:12])
    else $error("sector index wrong");
  AST_BLOCK: assert property (addr_valid |-> block_index == array_addr[17:16])
    else $error("block index wrong");
  AST_WP_OFF: assert property (data_lane2_in [*3] |-> region_lock_eff == 4'h0)
    else $error("lock bits active without pin");
  AST_QUAD_WP: assert property (quad_mode_bit [*4] |-> !write_protect_active)
    else $error("write protect active in quad mode");
  AST_LANES: assert property (!quad_mode_bit |-> !data_lane2_oe && !data_lane3_oe)
    else $error("extra lane driven outside quad mode");
  AST_PAUSE: assert property ((!quad_mode_bit && !data_lane3_in) [*6] |-> !cmd_valid && !addr_valid)
    else $error("progress while paused");
  AST_MODE: assert property ((cs_n && $stable(sck)) [*6] |-> clock_mode3 == sck)
    else $error("clock mode not tracked");
  AST_PULSE: assert property (cmd_valid |=> !cmd_valid)
    else $error("command strobe too long");
endmodule // sfp_monitor
bind sfp_spi_front sfp_monitor i_mon (.clk_sys, .rstn, .cs_n, .sck, .selected, .so_oe, .si_oe,
  .cmd_valid, .addr_valid, .array_addr, .sector_index, .block_index, .quad_mode_bit,
  .write_protect_active, .region_lock_eff, .data_lane2_oe, .data_lane3_oe, .data_lane3_in,
  .data_lane2_in, .clock_mode3);

/* bench/sfp_host.sv */
`timescale 1ns/1ps
module sfp_host (
  output reg cs_n,
  output reg sck,
  output reg si,
  output reg hold_n,
  input wire so
);
  reg mode3 = 1'b0;
  integer hold_at = -1;
  integer nb;
  reg [7:0] so_sh = 8'h00;
  initial
  begin
    cs_n = 1'b1;
    sck = 1'b0;
    si = 1'b0;
    hold_n = 1'b1;
  end
  task set_mode(input b);
    mode3 = b;
    sck = b;
    #500;
  endtask
  // pause keeps the sequence; clock wiggles must be ignored
  task pause;
    hold_n = 1'b0;
    #200 sck = ~sck;
    #100 sck = ~sck;
    #200 hold_n = 1'b1;
    #200;
  endtask
  task automatic frame(input logic [7:0] q[$]);
    integer i;
    cs_n = 1'b0;
    nb = 0;
    #100;
    foreach (q[k])
      for (i = 7; i >= 0; i--)
      begin
        if (nb == hold_at) pause();
        nb++;
        sck = 1'b0;
        si = q[k][i];
        #100 sck = 1'b1;
        so_sh = {so_sh[6:0], so};
        #100;
      end
    #100 sck = mode3;
    // serial input toggles after deselect and must be ignored
    #100 cs_n = 1'b1;
    si = ~si;
    #400;
  endtask
endmodule // sfp_host

/* bench/serial_flash_spi_pin_interface_bench.sv */
`timescale 1ns/1ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin mismatches++; \
  $display("BAD %0t got %h want %h", $time, g, e); end end
module serial_flash_spi_pin_interface_bench;
  reg clk_sys = 1'b0, rstn = 1'b0, quad_mode_bit = 1'b0, wp_n = 1'b1, rx_ready = 1'b1;
  reg tx_enable = 1'b1, tx_valid = 1'b1;
  reg [3:0] lock = 4'h0;
  reg [7:0] tx_data = 8'h5a;
  reg [31:0] seed = 32'hbbc755d0;
  wire cs_n, sck, si, hold_n, si_out, si_oe, d2_out, d2_oe, d3_out, d3_oe, tx_ready, rx_valid;
  wire so_out, so_oe, frame_end;
  wire [7:0] cmd_code, rx_data;
  wire [17:0] array_addr;
  wire [5:0] sector_index;
  wire [1:0] block_index;
  wire [3:0] region_lock_eff;
  wire rx_overflow, clock_mode3, write_protect_active;
  integer mismatches = 0, checks_done = 0, cycles = 0, k, md;
  integer frames_seen = 0, frames_sent = 0;
  logic [7:0] got[$], exp_rx[$];
  initial
    forever #12.5 clk_sys = ~clk_sys;
  // released output line floats to its pull-up level
  sfp_host i_host (.cs_n(cs_n), .sck(sck), .si(si), .hold_n(hold_n),
    .so(so_oe ? so_out : 1'b1));
  sfp_spi_front i_dut (.clk_sys(clk_sys), .rstn(rstn), .cs_n(cs_n), .sck(sck),
    .si_in(si_oe ? si_out : si), .si_out(si_out), .si_oe(si_oe), .so_out(so_out), .so_oe(so_oe),
    .data_lane2_in(d2_oe ? d2_out : wp_n), .data_lane2_out(d2_out), .data_lane2_oe(d2_oe),
    .data_lane3_in(d3_oe ? d3_out : hold_n), .data_lane3_out(d3_out), .data_lane3_oe(d3_oe),
    .quad_mode_bit(quad_mode_bit), .region_lock_bit0(lock[0]), .region_lock_bit1(lock[1]),
    .region_lock_bit2(lock[2]), .region_lock_bit3(lock[3]), .quad_rx(1'b0),
    .tx_enable(tx_enable), .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data),
    .cmd_valid(), .cmd_code(cmd_code), .addr_valid(), .array_addr(array_addr),
    .sector_index(sector_index), .block_index(block_index), .rx_valid(rx_valid),
    .rx_ready(rx_ready), .rx_data(rx_data), .rx_overflow(rx_overflow),
    .clock_mode3(clock_mode3), .selected(), .write_protect_active(write_protect_active),
    .region_lock_eff(region_lock_eff), .frame_end(frame_end));
  function automatic [31:0] xs(input [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  // mode 0 has one rise before the first launching fall, so the byte shows rotated
  function automatic [7:0] so_exp(input [7:0] d, input m3);
    so_exp = m3 ? d : {d[0], d[7:1]};
  endfunction
  task stop_test;
    $display("checks_done %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  always @(posedge clk_sys)
  begin
    cycles <= cycles + 1;
    if (rx_valid === 1'b1 && rx_ready) got.push_back(rx_data);
    if (frame_end === 1'b1) frames_seen <= frames_seen + 1;
    if (cycles == 30000)
    begin
      mismatches++;
      stop_test;
    end
  end
  task cmp_rx;
    reg [7:0] g;
    reg [7:0] e;
    repeat (20) @(negedge clk_sys);
    `CHK(got.size(), exp_rx.size())
    while (got.size() > 0 && exp_rx.size() > 0)
    begin
      g = got.pop_front();
      e = exp_rx.pop_front();
      `CHK(g, e)
    end
    got.delete();
    exp_rx.delete();
  endtask
  task automatic run(input [7:0] cmd, input [23:0] a, input integer n);
    logic [7:0] q[$];
    q = {cmd, a[23:16], a[15:8], a[7:0]};
    for (k = 0; k < n; k++)
    begin
      seed = xs(seed);
      q.push_back(seed[7:0]);
      // eight stored words plus the staged output word survive a stalled reader
      if (k < 9 || rx_ready) exp_rx.push_back(seed[7:0]);
    end
    @(negedge clk_sys) tx_data = seed[15:8];
    i_host.frame(q);
    frames_sent++;
    `CHK(frames_seen, frames_sent)
    `CHK(i_host.so_sh, so_exp(tx_data, i_host.mode3))
    `CHK(cmd_code, cmd)
    `CHK(array_addr, a[17:0])
    `CHK(sector_index, a[17:12])
    `CHK(block_index, a[17:16])
    if (rx_ready) cmp_rx;
  endtask
  initial
  begin
    repeat (3) @(negedge clk_sys);
    rstn = 1'b1;
    `CHK(cmd_code, 8'h00)
    for (md = 0; md < 2; md++)
    begin
      i_host.set_mode(md[0]);
      `CHK(clock_mode3, md[0])
      run(8'h03, 24'hffffff, 2);
      seed = xs(seed);
      run(seed[31:24], seed[23:0], 1);
    end
    i_host.hold_at = 31;
    run(8'h0b, 24'h03f000, 1);
    i_host.hold_at = -1;
    for (k = 0; k < 6; k++)
    begin
      seed = xs(seed);
      @(negedge clk_sys);
      lock = seed[3:0];
      wp_n = seed[4] && k != 5;
      quad_mode_bit = (k == 5);
      repeat (6) @(negedge clk_sys);
      `CHK(write_protect_active, !wp_n && !quad_mode_bit)
      `CHK(region_lock_eff, (!wp_n && !quad_mode_bit) ? lock : 4'h0)
    end
    `CHK(write_protect_active, 1'b0)
    @(negedge clk_sys);
    quad_mode_bit = 1'b0;
    wp_n = 1'b1;
    rx_ready = 1'b0;
    run(8'h02, 24'h010000, 10);
    `CHK(rx_overflow, 1'b1)
    @(negedge clk_sys) rx_ready = 1'b1;
    cmp_rx;
    stop_test;
  end
endmodule // serial_flash_spi_pin_interface_bench
